/* meter_display_pkg.sv */
// constants and carrier types for the meter display and result registers
package meter_display_pkg;
  localparam int DATA_W = 16;
  localparam int SEG3_W = 8;
  localparam int CONV_W = 20;
  localparam int ADDR_W = 3;

  // register indices on the access port
  localparam logic [ADDR_W-1:0] IDX_SEG_ONE    = 3'h0;
  localparam logic [ADDR_W-1:0] IDX_SEG_TWO    = 3'h1;
  localparam logic [ADDR_W-1:0] IDX_SEG_THREE  = 3'h2;
  localparam logic [ADDR_W-1:0] IDX_CUST_OFFS  = 3'h3;
  localparam logic [ADDR_W-1:0] IDX_RESULT_UP  = 3'h4;
  localparam logic [ADDR_W-1:0] IDX_DISPLAY    = 3'h5;
  localparam logic [ADDR_W-1:0] IDX_PEAK       = 3'h6;

  // reset values
  localparam logic [DATA_W-1:0] RST_WORD  = 16'h0000;
  localparam logic [SEG3_W-1:0] RST_SEG3  = 8'h00;
  localparam logic [CONV_W-1:0] RST_CONV  = 20'h00000;

  // field layouts
  localparam logic [DATA_W-1:0] SEG_WORD_MASK   = 16'hfffe;
  localparam logic [DATA_W-1:0] SEG2_DIGIT4_MSK = 16'he000;
  localparam logic [SEG3_W-1:0] SEG3_DIGIT4_MSK = 8'h1f;
  localparam logic [DATA_W-1:0] SHORT_RES_MASK  = 16'hfff0;
  localparam int SEG2_BATT_BIT   = 3;
  localparam int SEG2_SIGN_BIT   = 12;
  localparam int SEG3_PEAK_BIT   = 7;
  localparam int SEG3_HOLD_BIT   = 6;
  localparam int SEG3_LEAD_BIT   = 5;
  localparam int SUB_BITS        = 4;

  // display source, one-hot
  typedef enum logic [4:0] {
    SRC_SEGMENTS = 5'b00001,
    SRC_USER     = 5'b00010,
    SRC_HELD     = 5'b00100,
    SRC_PEAK     = 5'b01000,
    SRC_RESULT   = 5'b10000
  } display_src_t;

  typedef struct packed {
    logic              wr;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } reg_access_t;

  typedef struct packed {
    logic              valid;
    logic [CONV_W-1:0] value;
  } conversion_t;

  typedef struct packed {
    logic segment_override_select;
    logic display_source_select;
    logic hold;
    logic peak_track;
  } display_ctrl_t;
endpackage

/* meter_display_result_regs.sv */
// register bank for segment override, offset, result, display data and peak
// Notes on behaviour
// - second segment word is 16-bit read/write, reset zero.
// - second segment word bits map digit-4, sign, digit-3, battery, digit-2; bit 0 zero.
// - with segment override selected, each segment bit drives one segment.
// - stored zero lights a segment, one blanks it; reset lights all.
// - bit 3 of second word drives battery warning, lit by default.
// - third segment word is 8-bit read/write, reset zero, peak/hold/lead-one/digit-4.
// - lead-one bit drives fifth or fourth digit; digit-4 bits only on long variant.
// - custom offset is 16-bit two's complement read/write, reset zero.
// - final result is calibrated input minus custom offset.
// - upper result word is read-only, reset zero, sixteen result MSBs.
// - short variant carries twelve bits, 15 down to 4; long variant sixteen.
// - display word read/write, reset zero, loads from result, peak or writes.
// - short variant display and peak words carry four trailing sub-bits; the code loads them from the masked upper word, so bits 3:0 are zero.
// - peak word read-only two's complement, reset zero, tracks only when enabled.
// - tracking start copies result; later only larger results overwrite.
// - clearing peak tracking clears the peak word.
// - peak tracking guaranteed only within the documented count range.
// - display source priority: segments, user data, held, peak, result.
// - first segment word is 16-bit read/write, reset zero, bit 0 zero.
// - hold stops display loading while conversions continue.
`timescale 1ns/1ps
`default_nettype none
module meter_display_result_regs
  import meter_display_pkg::*;
#(
  parameter bit FOUR_HALF_DIGIT = 1'b1
) (
  input  wire logic                              clock,
  input  wire logic                              rst,
  input  wire meter_display_pkg::reg_access_t    reg_req,
  output logic [meter_display_pkg::DATA_W-1:0]   reg_rdata,
  input  wire meter_display_pkg::conversion_t    conv_in,
  input  wire meter_display_pkg::display_ctrl_t  ctrl,
  input  wire logic                              battery_low,
  output logic [meter_display_pkg::CONV_W-1:0]   result_full,
  output logic [meter_display_pkg::DATA_W-1:0]   display_word,
  output logic                                   display_segments_mode,
  output logic [meter_display_pkg::DATA_W-1:0]   seg_lit_one,
  output logic [meter_display_pkg::DATA_W-1:0]   seg_lit_two,
  output logic [meter_display_pkg::SEG3_W-1:0]   seg_lit_three,
  output logic                                   battery_warn_segment,
  output logic                                   leading_one_segment
);
  import meter_display_pkg::*;

  logic [DATA_W-1:0] seg_one_ff, seg_two_ff, offset_ff, result_up_ff;
  logic [DATA_W-1:0] display_ff, peak_ff, rdata_ff;
  logic [SEG3_W-1:0] seg_three_ff;
  logic [CONV_W-1:0] result_full_ff;
  logic              peak_prev_ff;
  display_src_t      src;

  // write decode
  wire wr_seg_one   = reg_req.wr && reg_req.addr == IDX_SEG_ONE;
  wire wr_seg_two   = reg_req.wr && reg_req.addr == IDX_SEG_TWO;
  wire wr_seg_three = reg_req.wr && reg_req.addr == IDX_SEG_THREE;
  wire wr_offset    = reg_req.wr && reg_req.addr == IDX_CUST_OFFS;
  wire wr_display   = reg_req.wr && reg_req.addr == IDX_DISPLAY;

  // result path: input minus offset aligned to the upper word
  wire [CONV_W-1:0] offset_ext = {offset_ff, {SUB_BITS{1'b0}}};
  wire [CONV_W-1:0] nxt_result_full = conv_in.value - offset_ext;
  wire [DATA_W-1:0] short_mask = FOUR_HALF_DIGIT ? {DATA_W{1'b1}} : SHORT_RES_MASK;
  wire [DATA_W-1:0] nxt_result_up =
    nxt_result_full[CONV_W-1:SUB_BITS] & short_mask;

  // peak tracking
  wire peak_start = ctrl.peak_track && !peak_prev_ff;
  wire peak_larger = $signed(nxt_result_up) > $signed(peak_ff);
  logic [DATA_W-1:0] nxt_peak;
  always_comb begin
    if (!ctrl.peak_track) begin
      nxt_peak = RST_WORD;
    end else if (peak_start) begin
      nxt_peak = conv_in.valid ? nxt_result_up : result_up_ff;
    end else if (conv_in.valid && peak_larger) begin
      nxt_peak = nxt_result_up;
    end else begin
      nxt_peak = peak_ff;
    end
  end

  // display source priority
  always_comb begin
    if (ctrl.segment_override_select) begin
      src = SRC_SEGMENTS;
    end else if (ctrl.display_source_select) begin
      src = SRC_USER;
    end else if (ctrl.hold) begin
      src = SRC_HELD;
    end else if (ctrl.peak_track) begin
      src = SRC_PEAK;
    end else begin
      src = SRC_RESULT;
    end
  end

  // display word loading; writes land only under segment, user or held source, peak and result reload every cycle
  logic [DATA_W-1:0] nxt_display;
  always_comb begin
    nxt_display = display_ff;
    unique case (src)
      SRC_SEGMENTS, SRC_USER, SRC_HELD: begin
        if (wr_display) begin
          nxt_display = reg_req.wdata;
        end
      end
      SRC_PEAK: begin
        nxt_display = nxt_peak;
      end
      SRC_RESULT: begin
        nxt_display = conv_in.valid ? nxt_result_up : result_up_ff;
      end
    endcase
  end

  // read mux; result and peak words are not writable
  logic [DATA_W-1:0] nxt_rdata;
  always_comb begin
    unique case (reg_req.addr)
      IDX_SEG_ONE:   nxt_rdata = seg_one_ff;
      IDX_SEG_TWO:   nxt_rdata = seg_two_ff;
      IDX_SEG_THREE: nxt_rdata = {{(DATA_W-SEG3_W){1'b0}}, seg_three_ff};
      IDX_CUST_OFFS: nxt_rdata = offset_ff;
      IDX_RESULT_UP: nxt_rdata = result_up_ff;
      IDX_DISPLAY:   nxt_rdata = display_ff;
      IDX_PEAK:      nxt_rdata = peak_ff;
      default:       nxt_rdata = RST_WORD;
    endcase
  end

  // segment and offset registers
  always_ff @(posedge clock) begin
    if (rst) begin
      seg_one_ff   <= RST_WORD;
      seg_two_ff   <= RST_WORD;
      seg_three_ff <= RST_SEG3;
      offset_ff    <= RST_WORD;
    end else begin
      if (wr_seg_one)   seg_one_ff   <= reg_req.wdata & SEG_WORD_MASK;
      if (wr_seg_two)   seg_two_ff   <= reg_req.wdata & SEG_WORD_MASK;
      if (wr_seg_three) seg_three_ff <= reg_req.wdata[SEG3_W-1:0];
      if (wr_offset)    offset_ff    <= reg_req.wdata;
    end
  end

  // result, peak, display and read data
  always_ff @(posedge clock) begin
    if (rst) begin
      result_full_ff <= RST_CONV;
      result_up_ff   <= RST_WORD;
      peak_ff        <= RST_WORD;
      peak_prev_ff   <= 1'b0;
      display_ff     <= RST_WORD;
      rdata_ff       <= RST_WORD;
    end else begin
      if (conv_in.valid) begin
        result_full_ff <= nxt_result_full;  // full result with lower nibble
        result_up_ff   <= nxt_result_up;
      end
      peak_ff      <= nxt_peak;
      peak_prev_ff <= ctrl.peak_track;
      display_ff   <= nxt_display;
      rdata_ff     <= nxt_rdata;
    end
  end

  // segment drive: zero lights; digit-4 segments only on the long variant
  wire [DATA_W-1:0] lit_two_raw   = ~seg_two_ff & SEG_WORD_MASK;
  wire [SEG3_W-1:0] lit_three_raw = ~seg_three_ff;
  wire [DATA_W-1:0] mask_two   = FOUR_HALF_DIGIT ? {DATA_W{1'b1}} : ~SEG2_DIGIT4_MSK;
  wire [SEG3_W-1:0] mask_three = FOUR_HALF_DIGIT ? {SEG3_W{1'b1}} : ~SEG3_DIGIT4_MSK;
  wire              ovr = ctrl.segment_override_select;

  assign seg_lit_one   = ovr ? (~seg_one_ff & SEG_WORD_MASK) : RST_WORD;
  assign seg_lit_two   = ovr ? (lit_two_raw & mask_two) : RST_WORD;
  assign seg_lit_three = ovr ? (lit_three_raw & mask_three) : RST_SEG3;
  assign battery_warn_segment =
    ovr ? ~seg_two_ff[SEG2_BATT_BIT] : battery_low;
  assign leading_one_segment = ovr && ~seg_three_ff[SEG3_LEAD_BIT];

  assign display_segments_mode = ovr;
  assign display_word = display_ff;
  assign result_full  = result_full_ff;
  assign reg_rdata    = rdata_ff;
endmodule
`default_nettype wire

/* meter_display_result_regs_tb.sv */
// self-checking testbench for the meter display register bank
`timescale 1ns/1ps
`default_nettype none
module meter_display_result_regs_tb;
  import meter_display_pkg::*;
  logic clock, rst, battery_low, display_segments_mode, battery_warn_segment, leading_one_segment;
  conversion_t conv_in;
  display_ctrl_t ctrl;
  reg_access_t reg_req;
  logic [DATA_W-1:0] reg_rdata, display_word, seg_lit_one, seg_lit_two, rd_v;
  logic [SEG3_W-1:0] seg_lit_three;
  logic [CONV_W-1:0] result_full;
  int err_total = 0;
  int comparisons = 0;
  meter_display_result_regs i_dut (.clock(clock), .rst(rst), .reg_req(reg_req),
    .reg_rdata(reg_rdata), .conv_in(conv_in), .ctrl(ctrl), .battery_low(battery_low),
    .result_full(result_full), .display_word(display_word),
    .display_segments_mode(display_segments_mode), .seg_lit_one(seg_lit_one),
    .seg_lit_two(seg_lit_two), .seg_lit_three(seg_lit_three),
    .battery_warn_segment(battery_warn_segment), .leading_one_segment(leading_one_segment));
  reg_host_model i_host (.clock(clock), .reg_rdata(reg_rdata), .reg_req(reg_req));
  // compare and count
  task automatic chk(input logic [CONV_W-1:0] got, input logic [CONV_W-1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    i_host.rd(a, rd_v);
    chk(rd_v, e);
  endtask
  // one conversion pulse, then valid dropped
  task automatic cv(input logic [CONV_W-1:0] v);
    @(posedge clock);
    #1 conv_in = '{1'b1, v};
    @(posedge clock);
    #1 conv_in.valid = 1'b0;
  endtask
  task automatic setc(input logic [3:0] c);
    @(posedge clock);
    #1 ctrl = c;
    #1;
  endtask
  task automatic t_reset;
    for (int i = 0; i < 8; i++) rchk(i[2:0], 16'h0000);
    chk(battery_warn_segment, 1'b1);
    setc(4'h8);
    chk({seg_lit_three, battery_warn_segment, leading_one_segment}, 10'h3ff);
    chk(seg_lit_one, 16'hfffe);
    chk(seg_lit_two, 16'hfffe);
    chk(display_segments_mode, 1'b1);
    $display("test reset done");
  endtask
  task automatic t_rw;
    i_host.wr(IDX_SEG_TWO, 16'hffff);
    rchk(IDX_SEG_TWO, 16'hfffe);
    chk(battery_warn_segment, 1'b0);
    i_host.wr(IDX_SEG_THREE, 16'h01df);
    rchk(IDX_SEG_THREE, 16'h00df);
    chk({leading_one_segment, seg_lit_three}, 9'h120);
    for (int i = 4; i < 8; i += 2) i_host.wr(i[2:0], 16'h5a5a);
    rchk(IDX_RESULT_UP, 16'h0000);
    rchk(IDX_PEAK, 16'h0000);
    $display("test register access done");
  endtask
  task automatic t_conv;
    setc(4'h0);
    i_host.wr(IDX_CUST_OFFS, 16'h0010);
    cv(20'h01000);
    chk(result_full, 20'h00f00);
    rchk(IDX_RESULT_UP, 16'h00f0);
    chk(display_word, 16'h00f0);
    i_host.wr(IDX_CUST_OFFS, 16'hfff0);
    rchk(IDX_CUST_OFFS, 16'hfff0);
    cv(20'h01000);
    chk(result_full, 20'h01100);
    rchk(IDX_RESULT_UP, 16'h0110);
    chk({rd_v, result_full[3:0]}, 20'h01100);
    $display("test conversion done");
  endtask
  task automatic t_peak;
    cv(20'h00400);
    setc(4'h1);
    cv(20'h00200);
    rchk(IDX_PEAK, 16'h0050);
    cv(20'h00700);
    cv(20'hffd00);
    rchk(IDX_PEAK, 16'h0080);
    chk(display_word, 16'h0080);
    setc(4'h0);
    rchk(IDX_PEAK, 16'h0000);
    $display("test peak done");
  endtask
  task automatic t_hold;
    cv(20'h00100);
    setc(4'h2);
    cv(20'h00500);
    chk({result_full, display_word}, 36'h006000020);
    setc(4'h4);
    i_host.wr(IDX_DISPLAY, 16'h1234);
    cv(20'h00000);
    rchk(IDX_DISPLAY, 16'h1234);
    chk(display_word, 16'h1234);
    $display("test hold and user done");
  endtask
  task automatic final_report;
    $display("comparisons=%0d mismatches=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  initial begin
    rst = 1'b1;
    battery_low = 1'b1;
    ctrl = '0;
    conv_in = '0;
    repeat (12) @(posedge clock);
    #1 rst = 1'b0;
    t_reset;
    t_rw;
    t_conv;
    t_peak;
    t_hold;
    final_report;
  end
  // watchdog
  initial begin
    #20000;
    err_total++;
    final_report;
  end
endmodule
`default_nettype wire

/* meter_display_sva.sv */
// assertion checker for the meter display register bank ports
`timescale 1ns/1ps
`default_nettype none
module meter_display_sva
  import meter_display_pkg::*;
#(parameter bit FOUR_HALF_DIGIT = 1'b1) (
  input wire logic                              clock,
  input wire logic                              rst,
  input wire meter_display_pkg::reg_access_t    reg_req,
  input wire logic [meter_display_pkg::DATA_W-1:0] reg_rdata,
  input wire meter_display_pkg::conversion_t    conv_in,
  input wire meter_display_pkg::display_ctrl_t  ctrl,
  input wire logic [meter_display_pkg::CONV_W-1:0] result_full,
  input wire logic [meter_display_pkg::DATA_W-1:0] display_word,
  input wire logic [meter_display_pkg::DATA_W-1:0] seg_lit_two,
  input wire logic [meter_display_pkg::SEG3_W-1:0] seg_lit_three,
  input wire logic                              battery_warn_segment,
  input wire logic                              leading_one_segment
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // helper: override flag and expected upper word
  wire logic              ovr    = ctrl.segment_override_select;
  wire logic [DATA_W-1:0] up_exp = result_full[CONV_W-1:4] & (FOUR_HALF_DIGIT ? 16'hffff : SHORT_RES_MASK);
  property p_no_lit; !ovr |-> seg_lit_two == 16'h0000 && seg_lit_three == 8'h00; endproperty
  a_no_lit: assert property (p_no_lit) else $error("segment lit without override");
  property p_batt; ovr && reg_req.wr && reg_req.addr == IDX_SEG_TWO |=> !ovr || battery_warn_segment == !$past(reg_req.wdata[SEG2_BATT_BIT]); endproperty
  a_batt: assert property (p_batt) else $error("battery segment wrong after write");
  property p_lead; ovr && reg_req.wr && reg_req.addr == IDX_SEG_THREE |=> !ovr || leading_one_segment == !$past(reg_req.wdata[SEG3_LEAD_BIT]); endproperty
  a_lead: assert property (p_lead) else $error("leading one segment wrong");
  property p_res_keep; !conv_in.valid |=> $stable(result_full); endproperty
  a_res_keep: assert property (p_res_keep) else $error("result moved without conversion");
  property p_rd_up; reg_req.addr == IDX_RESULT_UP |=> reg_rdata == $past(up_exp); endproperty
  a_rd_up: assert property (p_rd_up) else $error("upper result read wrong");
  property p_peak_clr; !ctrl.peak_track ##1 (!ctrl.peak_track && reg_req.addr == IDX_PEAK) |=> reg_rdata == 16'h0000; endproperty
  a_peak_clr: assert property (p_peak_clr) else $error("peak not cleared");
  property p_held; ctrl.hold && !ctrl.display_source_select && !ovr && !reg_req.wr |=> $stable(display_word); endproperty
  a_held: assert property (p_held) else $error("display moved under hold");
  property p_src_res; ctrl == 4'h0 && conv_in.valid |=> display_word == up_exp; endproperty
  a_src_res: assert property (p_src_res) else $error("display not loaded from result");
endmodule
bind meter_display_result_regs meter_display_sva #(.FOUR_HALF_DIGIT(FOUR_HALF_DIGIT)) i_sva (
  .clock(clock), .rst(rst), .reg_req(reg_req), .reg_rdata(reg_rdata), .conv_in(conv_in),
  .ctrl(ctrl), .result_full(result_full), .display_word(display_word), .seg_lit_two(seg_lit_two),
  .seg_lit_three(seg_lit_three), .battery_warn_segment(battery_warn_segment),
  .leading_one_segment(leading_one_segment));
`default_nettype wire

/* reg_host_model.sv */
// host model driving the register access port
`timescale 1ns/1ps
`default_nettype none
module reg_host_model
  import meter_display_pkg::*;
(
  input  wire logic                                 clock,
  input  wire logic [meter_display_pkg::DATA_W-1:0] reg_rdata,
  output var meter_display_pkg::reg_access_t        reg_req
);
  initial reg_req = '0;
  // one-cycle write strobe; stale data inverted once released
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clock);
    #1 reg_req = '{1'b1, a, d};
    @(posedge clock);
    #1 reg_req.wr = 1'b0;
    reg_req.wdata = ~d;
  endtask
  // address sampled at one edge, data taken after it
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clock);
    #1 reg_req.addr = a;
    @(posedge clock);
    #1 d = reg_rdata;
  endtask
endmodule
`default_nettype wire
